/* File: common/aesacc_params.svh */
`ifndef AESACC_PARAMS_SVH
`define AESACC_PARAMS_SVH

// Cycles from start to result, per key length
`define AESACC_LAT128 52
`define AESACC_LAT256 75

// Least latencies the core accepts; the iterative datapath can meet 21 (128-bit) and 28 (256-bit)
`define AESACC_MIN128 22
`define AESACC_MIN256 28

// Byte offsets
`define AESACC_OFF_CTRL   8'h00
`define AESACC_OFF_STATUS 8'h04
`define AESACC_OFF_DATA   8'h10
`define AESACC_OFF_KEY    8'h20

// Field positions
`define AESACC_CTRL_START 0
`define AESACC_CTRL_DEC   1
`define AESACC_CTRL_K256  2
`define AESACC_STAT_BUSY  0
`define AESACC_STAT_DONE  1

// Bus encodings and reset values
`define AESACC_HSIZE_WORD 3'h2
`define AESACC_RCON_INIT  8'h01

`endif

/* File: common/aesacc_pkg.sv */
`default_nettype none

package aesacc_pkg;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_expand = 2'b01,
    st_round  = 2'b10,
    st_hold   = 2'b11
  } aesacc_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] size;
    logic [7:0] addr;
  } aesacc_aphase_t;

  typedef struct packed {
    logic k256;
    logic dec;
  } aesacc_mode_t;

endpackage : aesacc_pkg

`default_nettype wire

/* File: hw/aesacc_core.sv */
`default_nettype none
`include "aesacc_params.svh"

module aesacc_core #(
  parameter int LAT128 = `AESACC_LAT128,
  parameter int LAT256 = `AESACC_LAT256
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire aesacc_pkg::aesacc_mode_t mode,
  input  wire logic [127:0]         din,
  input  wire logic [255:0]         key,
  output logic                      busy,
  output logic                      done,
  output logic [127:0]              dout
);

  if (LAT128 < `AESACC_MIN128 || LAT256 < `AESACC_MIN256 || LAT128 > 127 || LAT256 > 127) begin : g_chk
    $error("aesacc_core: latency outside what the datapath can serve");
  end

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction : xt

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] s;
    p = 8'h00;
    s = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ s;
      s = xt(s);
    end
    return p;
  endfunction : gmul

  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    logic [15:0] d;
    d = {x, x};
    return d[15-n -: 8];
  endfunction : rl

  // Field inverse as a to the power 254
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] s;
    r = 8'h01;
    s = a;
    for (int i = 1; i < 8; i++) begin
      s = gmul(s, s);
      r = gmul(r, s);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] x;
    x = ginv(a);
    return x ^ rl(x, 1) ^ rl(x, 2) ^ rl(x, 3) ^ rl(x, 4) ^ 8'h63;
  endfunction : sbox

  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
  endfunction : isbox

  function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
    logic [31:0]  cw;
    logic [7:0]   y;
    logic [127:0] o;
    cw = inv ? 32'h0e0b0d09 : 32'h02030101;
    o = 128'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        y = 8'h00;
        for (int j = 0; j < 4; j++) begin
          y = y ^ gmul(s[127-32*c-8*((r+j)%4) -: 8], cw[31-8*j -: 8]);
        end
        o[127-32*c-8*r -: 8] = y;
      end
    end
    return o;
  endfunction : mix

  // One cipher round, forward or inverse
  function automatic logic [127:0] rnd(input logic [127:0] s, input logic [127:0] k,
                                       input logic inv, input logic last);
    logic [127:0] o;
    o = 128'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (inv) o[127-8*(4*c+r) -: 8] = isbox(s[127-8*(4*((c+4-r)%4)+r) -: 8]);
        else     o[127-8*(4*c+r) -: 8] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
      end
    end
    if (inv) o = o ^ k;
    if (!last) o = mix(o, inv);
    if (!inv) o = o ^ k;
    return o;
  endfunction : rnd

  // Next four schedule words from the window
  function automatic logic [127:0] kstep(input logic [255:0] w, input logic k256,
                                         input logic use_rc, input logic [7:0] rc);
    logic [31:0]  t;
    logic [127:0] b;
    logic [127:0] n;
    t = w[31:0];
    if (use_rc) t = {t[23:0], t[31:24]};
    t = {sbox(t[31:24]), sbox(t[23:16]), sbox(t[15:8]), sbox(t[7:0])};
    if (use_rc) t[31:24] = t[31:24] ^ rc;
    b = k256 ? w[255:128] : w[127:0];
    n[127:96] = b[127:96] ^ t;
    n[95:64]  = b[95:64] ^ n[127:96];
    n[63:32]  = b[63:32] ^ n[95:64];
    n[31:0]   = b[31:0] ^ n[63:32];
    return n;
  endfunction : kstep

  aesacc_pkg::aesacc_state_t state_reg, state_next;
  aesacc_pkg::aesacc_mode_t  mode_reg, mode_next;
  logic [6:0]   cnt_reg, cnt_next;
  logic [3:0]   idx_reg, idx_next;
  logic [7:0]   rc_reg, rc_next;
  logic [255:0] win_reg, win_next;
  logic [127:0] st_reg, st_next;
  logic [127:0] rk_reg [15];
  logic [127:0] rk_next [15];
  logic [127:0] kw;
  logic         use_rc;
  logic [3:0]   nr;
  logic [6:0]   lat;

  assign nr   = mode_reg.k256 ? 4'he : 4'ha;
  assign lat  = mode_reg.k256 ? 7'(LAT256) : 7'(LAT128);
  assign busy = (state_reg != aesacc_pkg::st_idle);
  // RULE2 RULE3 fixed latency
  assign done = (state_reg == aesacc_pkg::st_hold) && (cnt_reg == lat);
  assign dout = st_reg;

  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    rc_next    = rc_reg;
    win_next   = win_reg;
    st_next    = st_reg;
    rk_next    = rk_reg;
    use_rc     = !mode_reg.k256 || !idx_reg[0];
    kw         = kstep(win_reg, mode_reg.k256, use_rc, rc_reg);
    case (state_reg)
      aesacc_pkg::st_idle: begin
        if (start) begin
          state_next = aesacc_pkg::st_expand;
          mode_next  = mode;
          cnt_next   = 7'h01;
          idx_next   = 4'h0;
          rc_next    = `AESACC_RCON_INIT;
          win_next   = mode.k256 ? key : {128'h0, key[255:128]};
          rk_next[0] = key[255:128];
          rk_next[1] = key[127:0];
          st_next    = din;
        end
      end
      // RULE1 key schedule
      aesacc_pkg::st_expand: begin
        cnt_next = cnt_reg + 7'h01;
        rk_next[mode_reg.k256 ? idx_reg + 4'h2 : idx_reg + 4'h1] = kw;
        win_next = mode_reg.k256 ? {win_reg[127:0], kw} : {128'h0, kw};
        if (use_rc) rc_next = xt(rc_reg);
        if (idx_reg == (mode_reg.k256 ? 4'hc : 4'h9)) begin
          state_next = aesacc_pkg::st_round;
          idx_next   = 4'h1;
          st_next    = st_reg ^ (mode_reg.dec ? kw : rk_reg[0]);
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      // RULE1 encrypt or decrypt rounds
      aesacc_pkg::st_round: begin
        cnt_next = cnt_reg + 7'h01;
        st_next  = rnd(st_reg, rk_reg[mode_reg.dec ? nr - idx_reg : idx_reg],
                       mode_reg.dec, idx_reg == nr);
        if (idx_reg == nr) state_next = aesacc_pkg::st_hold;
        else idx_next = idx_reg + 4'h1;
      end
      aesacc_pkg::st_hold: begin
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == lat) state_next = aesacc_pkg::st_idle;
      end
      default: state_next = aesacc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= aesacc_pkg::st_idle;
      mode_reg  <= '0;
      cnt_reg   <= 7'h00;
      idx_reg   <= 4'h0;
      rc_reg    <= `AESACC_RCON_INIT;
      win_reg   <= 256'h0;
      st_reg    <= 128'h0;
      for (int i = 0; i < 15; i++) rk_reg[i] <= 128'h0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      rc_reg    <= rc_next;
      win_reg   <= win_next;
      st_reg    <= st_next;
      rk_reg    <= rk_next;
    end
  end

endmodule : aesacc_core

`default_nettype wire

/* File: hw/aesacc_top.sv */
`default_nettype none
`include "aesacc_params.svh"

// Contract
// RULE1 - The block encrypts or decrypts with a 128-bit or 256-bit key chosen per operation.
// RULE2 - With a 128-bit key one 128-bit block finishes exactly 52 core clock cycles after start.
// RULE3 - With a 256-bit key one 128-bit block finishes exactly 75 core clock cycles after start.
// RULE4 - The data and key registers are reached through an AHB slave port.
// RULE5 - The bus master writes to the block only with full 32-bit transfers.
// RULE6 - On completion a readable done flag is set and the result stands in the data registers.
module aesacc_top #(
  parameter int LAT128 = `AESACC_LAT128,
  parameter int LAT256 = `AESACC_LAT256
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  aesacc_pkg::aesacc_aphase_t ap_reg, ap_next;
  aesacc_pkg::aesacc_mode_t   mode_reg, mode_next;
  logic [31:0]  hrdata_reg, hrdata_next;
  logic         done_reg, done_next;
  logic [31:0]  data_reg [4];
  logic [31:0]  data_next [4];
  logic [31:0]  key_reg [8];
  logic [31:0]  key_next [8];
  logic         wr_ok;
  logic         wr_ctrl;
  logic         wr_stat;
  logic         go;
  logic [127:0] din;
  logic [255:0] key;
  logic         core_busy;
  logic         core_done;
  logic [127:0] core_dout;

  // RULE4 zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // RULE5 narrow writes are dropped
  assign wr_ok   = ap_reg.valid && ap_reg.write && (ap_reg.size == `AESACC_HSIZE_WORD);
  assign wr_ctrl = wr_ok && ({ap_reg.addr[7:2], 2'b00} == `AESACC_OFF_CTRL);
  assign wr_stat = wr_ok && ({ap_reg.addr[7:2], 2'b00} == `AESACC_OFF_STATUS);
  assign go      = wr_ctrl && hwdata[`AESACC_CTRL_START] && !core_busy;

  assign din = {data_reg[0], data_reg[1], data_reg[2], data_reg[3]};
  assign key = {key_reg[0], key_reg[1], key_reg[2], key_reg[3],
                key_reg[4], key_reg[5], key_reg[6], key_reg[7]};

  // Address phase capture and read data
  always_comb begin
    ap_next     = '0;
    hrdata_next = 32'h0;
    if (hsel && hready && htrans[1]) begin
      ap_next.valid = 1'b1;
      ap_next.write = hwrite;
      ap_next.size  = hsize;
      ap_next.addr  = haddr[7:0];
      // RULE4 register read decode
      if (!hwrite) begin
        if ({haddr[7:2], 2'b00} == `AESACC_OFF_CTRL) begin
          hrdata_next[`AESACC_CTRL_DEC]  = mode_reg.dec;
          hrdata_next[`AESACC_CTRL_K256] = mode_reg.k256;
        end else if ({haddr[7:2], 2'b00} == `AESACC_OFF_STATUS) begin
          hrdata_next[`AESACC_STAT_BUSY] = core_busy;
          hrdata_next[`AESACC_STAT_DONE] = done_reg;
        end else if ((haddr[7:0] & 8'hf0) == `AESACC_OFF_DATA) begin
          hrdata_next = data_reg[haddr[3:2]];
        end
      end
    end
  end

  // Register writes, completion capture
  always_comb begin
    mode_next = mode_reg;
    done_next = done_reg;
    data_next = data_reg;
    key_next  = key_reg;
    // RULE1 mode chosen at each start
    if (wr_ctrl && !core_busy) begin
      mode_next.dec  = hwdata[`AESACC_CTRL_DEC];
      mode_next.k256 = hwdata[`AESACC_CTRL_K256];
    end
    if (wr_ok && !core_busy && ((ap_reg.addr & 8'hf0) == `AESACC_OFF_DATA)) begin
      data_next[ap_reg.addr[3:2]] = hwdata;
    end
    if (wr_ok && !core_busy && ((ap_reg.addr & 8'he0) == `AESACC_OFF_KEY)) begin
      key_next[ap_reg.addr[4:2]] = hwdata;
    end
    if (go) done_next = 1'b0;
    if (wr_stat && hwdata[`AESACC_STAT_DONE]) done_next = 1'b0;
    // RULE6 set wins over clear
    if (core_done) begin
      done_next    = 1'b1;
      data_next[0] = core_dout[127:96];
      data_next[1] = core_dout[95:64];
      data_next[2] = core_dout[63:32];
      data_next[3] = core_dout[31:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_reg     <= '0;
      hrdata_reg <= 32'h0;
      mode_reg   <= '0;
      done_reg   <= 1'b0;
      for (int i = 0; i < 4; i++) data_reg[i] <= 32'h0;
      for (int i = 0; i < 8; i++) key_reg[i] <= 32'h0;
    end else begin
      ap_reg     <= ap_next;
      hrdata_reg <= hrdata_next;
      mode_reg   <= mode_next;
      done_reg   <= done_next;
      data_reg   <= data_next;
      key_reg    <= key_next;
    end
  end

  aesacc_core #(
    .LAT128 (LAT128),
    .LAT256 (LAT256)
  ) u_core (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (go),
    .mode    (mode_next),
    .din     (din),
    .key     (key),
    .busy    (core_busy),
    .done    (core_done),
    .dout    (core_dout)
  );

  // RULE2 short key latency
  a_lat_short_key: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_n)
    (go && !hwdata[`AESACC_CTRL_K256]) |-> ##52 core_done
  ) else $error("128-bit operation did not finish in 52 cycles");

  // RULE2 no early completion
  a_no_early_done: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_n)
    go |-> ##1 (!core_done && core_busy)[*8]
  ) else $error("completion seen too soon after start");

  // RULE3 long key latency
  a_lat_long_key: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_n)
    (go && hwdata[`AESACC_CTRL_K256]) |-> ##75 core_done
  ) else $error("256-bit operation did not finish in 75 cycles");

  // RULE1 mode latched with start
  a_mode_latched: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!rst_n)
    go |=> (mode_reg.dec == $past(hwdata[`AESACC_CTRL_DEC]))
           && (mode_reg.k256 == $past(hwdata[`AESACC_CTRL_K256]))
  ) else $error("mode bits not taken at start");

  // RULE6 flag and result together
  a_done_result: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_n)
    core_done |=> done_reg && !core_busy && (data_reg[3] == $past(core_dout[31:0]))
  ) else $error("result or done flag missing at completion");

  // RULE6 done flag stays set
  a_done_sticky: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_n)
    (done_reg && !go && !(wr_stat && hwdata[`AESACC_STAT_DONE])) |=> done_reg
  ) else $error("done flag lost without a clear");

  // RULE4 status read back
  a_status_read: assert property ( // RULE4
    @(posedge sys_clk) disable iff (!rst_n)
    (hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == `AESACC_OFF_STATUS))
    |=> (hrdata[`AESACC_STAT_DONE] == $past(done_reg))
        && (hrdata[`AESACC_STAT_BUSY] == $past(core_busy))
  ) else $error("status read does not show block state");

  // RULE5 narrow write has no effect
  a_narrow_drop: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!rst_n)
    (ap_reg.valid && ap_reg.write && (ap_reg.size != `AESACC_HSIZE_WORD) && !core_done)
    |=> $stable(mode_reg) && $stable(data_reg[0]) && $stable(data_reg[3])
        && $stable(key_reg[0]) && $stable(key_reg[7])
  ) else $error("narrow write changed a register");

  // RULE2 still busy and not done at cycle 51
  a_short_not_early: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_n)
    (go && !hwdata[`AESACC_CTRL_K256]) |-> ##51 (!core_done && core_busy)
  ) else $error("128-bit operation finished before 52 cycles");

  // RULE3 still busy and not done at cycle 74
  a_long_not_early: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_n)
    (go && hwdata[`AESACC_CTRL_K256]) |-> ##74 (!core_done && core_busy)
  ) else $error("256-bit operation finished before 75 cycles");

  // RULE1 setup held while busy
  a_busy_hold: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_ok && core_busy && !core_done)
    |=> $stable(mode_reg) && $stable(data_reg[0]) && $stable(key_reg[1])
  ) else $error("register changed by a write while busy");

  // RULE4 data words read back
  a_data_read: assert property ( // RULE4
    @(posedge sys_clk) disable iff (!rst_n)
    (hsel && hready && htrans[1] && !hwrite && ((haddr[7:0] & 8'hf0) == `AESACC_OFF_DATA))
    |=> (hrdata == $past(data_reg[haddr[3:2]]))
  ) else $error("data read does not show the data register");

endmodule : aesacc_top

`default_nettype wire

/* File: testbench/aesacc_ahb_master.sv */
`default_nettype none

module aesacc_ahb_master (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hready,
  output logic             rd_valid,
  output logic [32:0]      rd_word
);
  timeunit 1ns;
  timeprecision 1ps;

  logic rd_pend;

  // Single slave: bus ready follows the slave
  assign hready = hreadyout;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend  <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_pend & hreadyout;
      if (hreadyout) begin
        rd_pend <= hsel & htrans[1] & ~hwrite;
      end
    end
  end

  always @(posedge sys_clk) begin
    rd_word <= {hresp, hrdata};
  end

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
  endtask : wait_rdy

  // transfer size taken from sz on every call
  // Request held until ready, released lines show inverted data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [2:0] sz,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= sz;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= wr ? d : ~hwdata;
    wait_rdy();
    hwdata <= ~hwdata;
  endtask : xfer

endmodule : aesacc_ahb_master

`default_nettype wire

/* File: testbench/aesacc_tb_top.sv */
`default_nettype none

module aesacc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LAT128 = 52;
  localparam int LAT256 = 75;
  localparam logic [255:0] key_fips = {128'h000102030405060708090a0b0c0d0e0f,
                                       128'h101112131415161718191a1b1c1d1e1f};
  localparam logic [127:0] pt_fips = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] ct_128  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] ct_256  = 128'h8ea2b7ca516745bfeafc49904b496089;

  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rd_valid;
  logic [32:0] rd_word;
  logic [31:0] exp_q[$];
  logic [255:0] key_v;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  aesacc_top #(.LAT128(LAT128), .LAT256(LAT256)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  aesacc_ahb_master mst (
    .sys_clk(sys_clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .rd_valid(rd_valid),
    .rd_word(rd_word));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Oldest noted read value against each read data phase, response OKAY
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("spare read", 33'h1, 33'h0);
      else
        check("hrdata", rd_word, {1'b0, exp_q.pop_front()});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst.xfer(1'b1, a, 3'h2, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    mst.xfer(1'b0, a, 3'h2, 32'h0);
  endtask : rd

  task automatic load(input logic [127:0] d);
    for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), key_v[255 - 32 * i -: 32]);
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), d[127 - 32 * i -: 32]);
  endtask : load

  task automatic rd_blk(input logic [127:0] e);
    for (int i = 0; i < 4; i++) rd(8'h10 + 8'(4 * i), e[127 - 32 * i -: 32]);
  endtask : rd_blk

  // Start, poke while busy when encrypting, probe STATUS at the last busy cycle (encrypt) or first done cycle (decrypt)
  task automatic run_op(input logic [31:0] ctrl);
    int   e0;
    int   lat;
    logic late;
    lat = ctrl[2] ? LAT256 : LAT128;
    late = ctrl[1];
    wr(8'h00, ctrl);
    e0 = cyc;
    if (!late) begin
      wr(8'h10, $urandom());
      wr(8'h00, 32'h7);
      wr(8'h24, $urandom());
    end
    while (cyc != e0 + lat - 1 + 32'(late)) @(posedge sys_clk);
    rd(8'h04, late ? 32'h2 : 32'h1);
    rd(8'h00, ctrl & 32'h6);
    if (!late) begin
      wr(8'h04, 32'h2);
      rd(8'h04, 32'h0);
    end
  endtask : run_op

  initial begin
    logic [127:0] blk;
    logic [31:0]  seed;
    rst_n = 1'b0;
    seed = $urandom(32'h1964b1e8);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    rd(8'h80, 32'h0);
    $display("test reset done");
    key_v = key_fips;
    load(pt_fips);
    run_op(32'h1);
    rd_blk(ct_128);
    run_op(32'h3);
    rd_blk(pt_fips);
    run_op(32'h5);
    rd_blk(ct_256);
    run_op(32'h7);
    rd_blk(pt_fips);
    $display("test known blocks done");
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 8; i++) key_v[32 * i +: 32] = $urandom();
      for (int i = 0; i < 4; i++) blk[32 * i +: 32] = $urandom();
      load(blk);
      mst.xfer(1'b1, 8'h1c, 3'($urandom_range(1, 0)), $urandom());
      run_op({29'h0, n[0], 2'b01});
      run_op({29'h0, n[0], 2'b11});
      rd_blk(blk);
    end
    $display("test round trips done");
    repeat (4) @(posedge sys_clk);
    check("pending reads", 33'(exp_q.size()), 33'h0);
    results();
  end

  // Whole run is under two thousand cycles; this is far beyond it
  initial begin
    #200us;
    error_cnt++;
    results();
  end

endmodule : aesacc_tb_top

`default_nettype wire
